// ### hw/cpu_registers_data_memory_map.sv
// cpu register set and data memory map with internal and auxiliary ram
//
// Overview of operation
// - main operand 8 bits, pairs with auxiliary
// - auxiliary operand register takes multiply/divide results
// - stack top pointer addresses push and pop
// - instruction pointer 16 bits, next instruction
// - reset loads instruction pointer to ff fe
// - carry flag takes alu carry or shift
// - half carry from bit three carry
// - two bank bits pick register bank
// - signed wrap flag on signed overflow
// - clear operation resets wrap flag only
// - bit test copies bit six
// - parity keeps total ones count even
// - external data pointer 16 bits, two bytes
// - internal, auxiliary ram and special space separate
// - bytes 32 to 47 bit addressable
// - window port with auto-incrementing index pointer
// - select bit zero maps moves to the low 256 bytes onto aux
// - aux moves served inside, no bus
// - special space only direct or bit access, 128 to 255
// - addresses ending 0 or 8 bit addressable
`timescale 1ns/1ps
`default_nettype none
module cpu_registers_data_memory_map (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // memory requests from the execution logic
    input wire cpu_regs_pkg::byte_req_t dir_req_i,
    input wire cpu_regs_pkg::byte_req_t ind_req_i,
    input wire cpu_regs_pkg::bit_req_t bit_req_i,
    input wire cpu_regs_pkg::xmv_req_t xmv_req_i,
    input wire cpu_regs_pkg::stack_req_t stack_req_i,
    // alu results and sequencing
    input wire cpu_regs_pkg::alu_upd_t alu_upd_i,
    input wire cpu_regs_pkg::seq_ctl_t seq_ctl_i,
    // answers
    output cpu_regs_pkg::byte_rsp_t byte_rsp_o,
    output cpu_regs_pkg::byte_rsp_t xmv_rsp_o,
    output logic bit_valid_o,
    output logic bit_data_o,
    // register view
    output cpu_regs_pkg::cpu_view_t view_o
);
    import cpu_regs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] main_operand_reg;
        logic [7:0] aux_operand_reg;
        logic [7:0] stack_top_pointer;
        logic carry_flag;
        logic half_carry_flag;
        logic user_flag;
        logic bank_select_high;
        logic bank_select_low;
        logic signed_wrap_flag;
        logic spare_flag;
        logic parity_flag;
        logic [15:0] instruction_pointer;
        logic [7:0] ext_pointer_high;
        logic [7:0] ext_pointer_low;
        logic [7:0] aux_ram_index_pointer;
        logic [7:0] extended_control;
        byte_rsp_t byte_rsp;
        byte_rsp_t xmv_rsp;
        logic bit_valid;
        logic bit_data;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] inc8(input logic [7:0] v);
        return v + ONE8;
    endfunction

    function automatic logic [7:0] dec8(input logic [7:0] v);
        return v - ONE8;
    endfunction

    function automatic logic [7:0] flag_word(input state_t s);
        logic [7:0] r;
        r = ZERO8;
        r[CY_BIT] = s.carry_flag;
        r[AC_BIT] = s.half_carry_flag;
        r[F0_BIT] = s.user_flag;
        r[RS1_BIT] = s.bank_select_high;
        r[RS0_BIT] = s.bank_select_low;
        r[OV_BIT] = s.signed_wrap_flag;
        r[UF_BIT] = s.spare_flag;
        r[P_BIT] = s.parity_flag;
        return r;
    endfunction

    // readable special registers; unmapped addresses read zero
    function automatic logic [7:0] sfr_read(input state_t s, input logic [7:0] a,
                                            input logic [7:0] win);
        logic [7:0] r;
        r = ZERO8;
        case (a)
            ADDR_MAIN_OPERAND: r = s.main_operand_reg;
            ADDR_AUX_OPERAND: r = s.aux_operand_reg;
            ADDR_STACK_TOP: r = s.stack_top_pointer;
            ADDR_EXT_LOW: r = s.ext_pointer_low;
            ADDR_EXT_HIGH: r = s.ext_pointer_high;
            ADDR_FLAG_WORD: r = flag_word(s);
            ADDR_WINDOW_PORT: r = win;
            ADDR_INDEX_PTR: r = s.aux_ram_index_pointer;
            ADDR_EXT_CONTROL: r = s.extended_control;
            default: r = ZERO8;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // memories
    // ----------------------------------------------------------------
    logic iram_we, xram_we, bit_in_ram;
    logic [7:0] iram_waddr, iram_wdata, iram_raddr, iram_rdata;
    logic [7:0] xram_waddr, xram_wdata, xram_raddr, xram_rdata;
    logic [7:0] xmv_addr, bit_byte_addr;

    // internal ram and auxiliary ram are separate arrays
    data_ram_256 iram_u (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .we_i(iram_we),
        .waddr_i(iram_waddr),
        .wdata_i(iram_wdata),
        .raddr_i(iram_raddr),
        .rdata_o(iram_rdata)
    );

    data_ram_256 xram_u (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .we_i(xram_we),
        .waddr_i(xram_waddr),
        .wdata_i(xram_wdata),
        .raddr_i(xram_raddr),
        .rdata_o(xram_rdata)
    );

    // ----------------------------------------------------------------
    // address selection
    // ----------------------------------------------------------------
    // kept apart from the main process so read data never loops back
    always_comb begin
        bit_in_ram = bit_req_i.addr < SFR_BASE;
        if (bit_in_ram) begin
            bit_byte_addr = BIT_RAM_BASE + {4'h0, bit_req_i.addr[6:3]};
        end else begin
            bit_byte_addr = bit_req_i.addr & BIT_SFR_MASK;
        end
        xmv_addr = xmv_req_i.via_ri ? xmv_req_i.ri_addr : st_reg.ext_pointer_low;
        if (stack_req_i.pop) begin
            iram_raddr = st_reg.stack_top_pointer;
        end else if (ind_req_i.rd || ind_req_i.wr) begin
            iram_raddr = ind_req_i.addr;
        end else if (dir_req_i.rd || dir_req_i.wr) begin
            iram_raddr = dir_req_i.addr;
        end else begin
            iram_raddr = bit_byte_addr;
        end
        // moves own the aux port; the window uses it otherwise
        xram_raddr = (xmv_req_i.rd || xmv_req_i.wr) ? xmv_addr : st_reg.aux_ram_index_pointer;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic sfr_we, win_touch, xmv_hit;
    logic [7:0] sfr_addr, sfr_wdata, byte_val;

    always_comb begin
        st_next = st_reg;
        st_next.byte_rsp.valid = 1'b0;
        st_next.xmv_rsp.valid = 1'b0;
        st_next.bit_valid = 1'b0;
        iram_we = 1'b0;
        iram_waddr = ZERO8;
        iram_wdata = ZERO8;
        xram_we = 1'b0;
        xram_waddr = ZERO8;
        xram_wdata = ZERO8;
        sfr_we = 1'b0;
        sfr_addr = ZERO8;
        sfr_wdata = ZERO8;
        win_touch = 1'b0;
        byte_val = ZERO8;
        xmv_hit = 1'b0;

        // internal ram requests, one served per cycle in priority order
        if (stack_req_i.push) begin
            st_next.stack_top_pointer = inc8(st_reg.stack_top_pointer);
            iram_we = 1'b1;
            iram_waddr = st_next.stack_top_pointer;
            iram_wdata = stack_req_i.wdata;
        end else if (stack_req_i.pop) begin
            st_next.stack_top_pointer = dec8(st_reg.stack_top_pointer);
            st_next.byte_rsp.valid = 1'b1;
            st_next.byte_rsp.data = iram_rdata;
        end else if (ind_req_i.rd || ind_req_i.wr) begin
            // indirect access reaches all 256 bytes but never special space
            if (ind_req_i.wr) begin
                iram_we = 1'b1;
                iram_waddr = ind_req_i.addr;
                iram_wdata = ind_req_i.wdata;
            end else begin
                st_next.byte_rsp.valid = 1'b1;
                st_next.byte_rsp.data = iram_rdata;
            end
        end else if (dir_req_i.rd || dir_req_i.wr) begin
            if (dir_req_i.addr >= SFR_BASE) begin
                // special space is reached only by direct and bit addressing
                win_touch = dir_req_i.addr == ADDR_WINDOW_PORT;
                if (dir_req_i.wr) begin
                    sfr_we = 1'b1;
                    sfr_addr = dir_req_i.addr;
                    sfr_wdata = dir_req_i.wdata;
                end else begin
                    st_next.byte_rsp.valid = 1'b1;
                    st_next.byte_rsp.data = sfr_read(st_reg, dir_req_i.addr, xram_rdata);
                end
            end else if (dir_req_i.wr) begin
                iram_we = 1'b1;
                iram_waddr = dir_req_i.addr;
                iram_wdata = dir_req_i.wdata;
            end else begin
                st_next.byte_rsp.valid = 1'b1;
                st_next.byte_rsp.data = iram_rdata;
            end
        end else if (bit_req_i.rd || bit_req_i.wr) begin
            // bit writes are read-modify-write of the holding byte
            byte_val = bit_in_ram ? iram_rdata : sfr_read(st_reg, bit_byte_addr, ZERO8);
            if (bit_req_i.wr) begin
                byte_val[bit_req_i.addr[2:0]] = bit_req_i.value;
                if (bit_in_ram) begin
                    iram_we = 1'b1;
                    iram_waddr = bit_byte_addr;
                    iram_wdata = byte_val;
                end else begin
                    sfr_we = 1'b1;
                    sfr_addr = bit_byte_addr;
                    sfr_wdata = byte_val;
                end
            end else begin
                st_next.bit_valid = 1'b1;
                st_next.bit_data = byte_val[bit_req_i.addr[2:0]];
            end
        end

        // special register writes
        if (sfr_we) begin
            case (sfr_addr)
                ADDR_MAIN_OPERAND: st_next.main_operand_reg = sfr_wdata;
                ADDR_AUX_OPERAND: st_next.aux_operand_reg = sfr_wdata;
                ADDR_STACK_TOP: st_next.stack_top_pointer = sfr_wdata;
                ADDR_EXT_LOW: st_next.ext_pointer_low = sfr_wdata;
                ADDR_EXT_HIGH: st_next.ext_pointer_high = sfr_wdata;
                ADDR_INDEX_PTR: st_next.aux_ram_index_pointer = sfr_wdata;
                ADDR_EXT_CONTROL: st_next.extended_control = sfr_wdata & EXT_CONTROL_MASK;
                ADDR_WINDOW_PORT: begin
                    xram_we = 1'b1;
                    xram_waddr = st_reg.aux_ram_index_pointer;
                    xram_wdata = sfr_wdata;
                end
                ADDR_FLAG_WORD: begin
                    // parity is computed, so its bit ignores writes
                    st_next.carry_flag = sfr_wdata[CY_BIT];
                    st_next.half_carry_flag = sfr_wdata[AC_BIT];
                    st_next.user_flag = sfr_wdata[F0_BIT];
                    st_next.bank_select_high = sfr_wdata[RS1_BIT];
                    st_next.bank_select_low = sfr_wdata[RS0_BIT];
                    st_next.signed_wrap_flag = sfr_wdata[OV_BIT];
                    st_next.spare_flag = sfr_wdata[UF_BIT];
                end
                default: ;
            endcase
        end

        // every window access steps the index for bulk transfers
        if (win_touch) st_next.aux_ram_index_pointer = inc8(st_reg.aux_ram_index_pointer);

        // external data moves to the low 256 bytes land in aux ram while the select bit is clear
        xmv_hit = !st_reg.extended_control[AUX_RAM_SELECT_BIT_BIT] &&
                  (xmv_req_i.via_ri || st_reg.ext_pointer_high == ZERO8);
        if (xmv_req_i.wr) begin
            if (xmv_hit) begin
                xram_we = 1'b1;
                xram_waddr = xmv_addr;
                xram_wdata = xmv_req_i.wdata;
            end
        end else if (xmv_req_i.rd) begin
            st_next.xmv_rsp.valid = 1'b1;
            st_next.xmv_rsp.data = xmv_hit ? xram_rdata : XMV_IDLE_DATA;
        end

        // alu results override same-cycle register writes
        if (alu_upd_i.acc_we) st_next.main_operand_reg = alu_upd_i.acc;
        if (alu_upd_i.b_we) st_next.aux_operand_reg = alu_upd_i.b;
        if (alu_upd_i.cy_we) st_next.carry_flag = alu_upd_i.cy;
        if (alu_upd_i.ac_we) st_next.half_carry_flag = alu_upd_i.ac;
        // no path sets the wrap flag except arithmetic, bit test and flag word writes
        if (alu_upd_i.ov_clr) begin
            st_next.signed_wrap_flag = 1'b0;
        end else if (alu_upd_i.bit_test) begin
            st_next.signed_wrap_flag = alu_upd_i.test_byte[SIGN_COPY_BIT];
        end else if (alu_upd_i.ov_we) begin
            st_next.signed_wrap_flag = alu_upd_i.ov;
        end
        st_next.parity_flag = ^st_next.main_operand_reg;

        // sequencing: a load beats an increment
        if (seq_ctl_i.ip_load) begin
            st_next.instruction_pointer = seq_ctl_i.ip_value;
        end else if (seq_ctl_i.ip_inc) begin
            st_next.instruction_pointer = st_reg.instruction_pointer + ONE16;
        end
        if (seq_ctl_i.ext_inc) begin
            {st_next.ext_pointer_high, st_next.ext_pointer_low} =
                {st_next.ext_pointer_high, st_next.ext_pointer_low} + ONE16;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // stack top gets a safe start even though software sets it anyway
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= '0;
            st_reg.stack_top_pointer <= STACK_TOP_RST;
            st_reg.instruction_pointer <= IP_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign byte_rsp_o = st_reg.byte_rsp;
    assign xmv_rsp_o = st_reg.xmv_rsp;
    assign bit_valid_o = st_reg.bit_valid;
    assign bit_data_o = st_reg.bit_data;
    assign view_o.ip = st_reg.instruction_pointer;
    assign view_o.ext_ptr = {st_reg.ext_pointer_high, st_reg.ext_pointer_low};
    assign view_o.ab_pair = {st_reg.aux_operand_reg, st_reg.main_operand_reg};
    assign view_o.sp = st_reg.stack_top_pointer;
    assign view_o.flags = flag_word(st_reg);
    // bank base is 8 times the bank number: 00, 08, 10 or 18
    assign view_o.bank_base = {3'b000, st_reg.bank_select_high,
                               st_reg.bank_select_low, 3'b000};
    assign view_o.ext_control = st_reg.extended_control;
endmodule
`default_nettype wire

// ### hw/cpu_regs_pkg.sv
// constants and carrier types for the cpu register file and data memory map
package cpu_regs_pkg;

    // ----------
    // special register addresses
    // ----------
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
    localparam logic [7:0] ADDR_EXT_LOW = 8'h82;
    localparam logic [7:0] ADDR_EXT_HIGH = 8'h83;
    localparam logic [7:0] ADDR_FLAG_WORD = 8'hd0;
    localparam logic [7:0] ADDR_WINDOW_PORT = 8'hd4;
    localparam logic [7:0] ADDR_INDEX_PTR = 8'hd6;
    localparam logic [7:0] ADDR_MAIN_OPERAND = 8'he0;
    localparam logic [7:0] ADDR_EXT_CONTROL = 8'he8;
    localparam logic [7:0] ADDR_AUX_OPERAND = 8'hf0;

    // ----------
    // reset values
    // ----------
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] STACK_TOP_RST = 8'h07;
    localparam logic [15:0] IP_RST = 16'hfffe;
    localparam logic [7:0] EXT_CONTROL_MASK = 8'h01;

    // ----------
    // flag word field positions
    // ----------
    localparam int CY_BIT = 7;
    localparam int AC_BIT = 6;
    localparam int F0_BIT = 5;
    localparam int RS1_BIT = 4;
    localparam int RS0_BIT = 3;
    localparam int OV_BIT = 2;
    localparam int UF_BIT = 1;
    localparam int P_BIT = 0;

    // ----------
    // memory layout
    // ----------
    localparam int RAM_DEPTH = 256;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] BIT_SFR_MASK = 8'hf8;
    localparam int AUX_RAM_SELECT_BIT_BIT = 0;
    localparam int SIGN_COPY_BIT = 6;
    localparam logic [7:0] XMV_IDLE_DATA = 8'hff;
    localparam logic [7:0] ONE8 = 8'h01;
    localparam logic [15:0] ONE16 = 16'h0001;

    // ----------
    // carrier types
    // ----------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } byte_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic value;
    } bit_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic via_ri;
        logic [7:0] ri_addr;
        logic [7:0] wdata;
    } xmv_req_t;

    typedef struct packed {
        logic push;
        logic pop;
        logic [7:0] wdata;
    } stack_req_t;

    typedef struct packed {
        logic acc_we;
        logic [7:0] acc;
        logic b_we;
        logic [7:0] b;
        logic cy_we;
        logic cy;
        logic ac_we;
        logic ac;
        logic ov_we;
        logic ov;
        logic ov_clr;
        logic bit_test;
        logic [7:0] test_byte;
    } alu_upd_t;

    typedef struct packed {
        logic ip_load;
        logic [15:0] ip_value;
        logic ip_inc;
        logic ext_inc;
    } seq_ctl_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_rsp_t;

    typedef struct packed {
        logic [15:0] ip;
        logic [15:0] ext_ptr;
        logic [15:0] ab_pair;
        logic [7:0] sp;
        logic [7:0] flags;
        logic [7:0] bank_base;
        logic [7:0] ext_control;
    } cpu_view_t;

endpackage

// ### hw/data_ram_256.sv
// byte-wide flip-flop memory with one write port and one read port
`timescale 1ns/1ps
`default_nettype none
module data_ram_256 (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // write port
    input wire logic we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // read port
    input wire logic [7:0] raddr_i,
    output logic [7:0] rdata_o
);
    import cpu_regs_pkg::*;

    typedef struct packed {
        logic [RAM_DEPTH-1:0][7:0] mem;
    } ram_state_t;

    ram_state_t ram_reg;
    ram_state_t ram_next;

    // write path; read is combinational so the owner can do read-modify-write
    always_comb begin
        ram_next = ram_reg;
        if (we_i) begin
            ram_next.mem[waddr_i] = wdata_i;
        end
    end

    // cleared at reset so simulation never reads unknown bytes
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ram_reg <= '0;
        end else begin
            ram_reg <= ram_next;
        end
    end

    assign rdata_o = ram_reg.mem[raddr_i];
endmodule
`default_nettype wire

// ### tb/cpu_exec_model.sv
// execution logic model issuing one request per cycle
`timescale 1ns/1ps
`default_nettype none
module cpu_exec_model (
    // clock
    input wire logic mclk_i,
    // requests
    output var cpu_regs_pkg::byte_req_t dir_req_o,
    output var cpu_regs_pkg::byte_req_t ind_req_o,
    output var cpu_regs_pkg::bit_req_t bit_req_o,
    output var cpu_regs_pkg::xmv_req_t xmv_req_o,
    output var cpu_regs_pkg::stack_req_t stack_req_o,
    output var cpu_regs_pkg::alu_upd_t alu_upd_o,
    output var cpu_regs_pkg::seq_ctl_t seq_ctl_o
);
    import cpu_regs_pkg::*;
    // every call drives all groups once; a request stands until the next call replaces it
    task put(input byte_req_t d, i, input bit_req_t b, input xmv_req_t x, input stack_req_t s,
             input alu_upd_t a, input seq_ctl_t q);
        {dir_req_o, ind_req_o, bit_req_o, xmv_req_o, stack_req_o, alu_upd_o, seq_ctl_o} =
            {d, i, b, x, s, a, q};
        @(posedge mclk_i);
        #1;
    endtask
    initial begin
        {dir_req_o, ind_req_o, bit_req_o, xmv_req_o, stack_req_o, alu_upd_o, seq_ctl_o} = '0;
    end
    task mem(input logic ind, input logic w, input logic [7:0] a, input logic [7:0] d);
        put(ind ? '0 : {!w, w, a, d}, ind ? {!w, w, a, d} : '0, '0, '0, '0, '0, '0);
    endtask
    task bitop(input logic w, input logic [7:0] a, input logic v);
        put('0, '0, {!w, w, a, v}, '0, '0, '0, '0);
    endtask
    task xmv(input logic w, input logic ri, input logic [7:0] a, input logic [7:0] d);
        put('0, '0, '0, {!w, w, ri, a, d}, '0, '0, '0);
    endtask
    task stk(input logic push, input logic [7:0] d);
        put('0, '0, '0, '0, {push, !push, d}, '0, '0);
    endtask
    task alu(input alu_upd_t u);
        put('0, '0, '0, '0, '0, u, '0);
    endtask
    task seq(input seq_ctl_t q);
        put('0, '0, '0, '0, '0, '0, q);
    endtask
endmodule
`default_nettype wire

// ### tb/cpu_map_chk.sv
// port checks for the register file and data memory map
`timescale 1ns/1ps
`default_nettype none
module cpu_map_chk (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // watched ports
    input wire cpu_regs_pkg::byte_req_t dir_req_i,
    input wire cpu_regs_pkg::byte_req_t ind_req_i,
    input wire cpu_regs_pkg::xmv_req_t xmv_req_i,
    input wire cpu_regs_pkg::stack_req_t stack_req_i,
    input wire cpu_regs_pkg::alu_upd_t alu_upd_i,
    input wire cpu_regs_pkg::seq_ctl_t seq_ctl_i,
    input wire cpu_regs_pkg::byte_rsp_t byte_rsp_o,
    input wire cpu_regs_pkg::byte_rsp_t xmv_rsp_o,
    input wire cpu_regs_pkg::cpu_view_t view_o
);
    import cpu_regs_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // requests that outrank a direct access in the same cycle
    wire logic steal = |{ind_req_i.rd, ind_req_i.wr, stack_req_i.push, stack_req_i.pop};
    // a direct read that no higher request can steal
    sequence s_lone_read;
        dir_req_i.rd && !dir_req_i.wr && !steal;
    endsequence
    // a flag word write that is sure to be served
    sequence s_flag_write;
        dir_req_i.wr && dir_req_i.addr == ADDR_FLAG_WORD && !steal;
    endsequence
    a_read_answer: assert property (s_lone_read |=> byte_rsp_o.valid)
        else $error("direct read unanswered");
    a_answer_cause: assert property (byte_rsp_o.valid |->
        $past(dir_req_i.rd || ind_req_i.rd || stack_req_i.pop)) else $error("stray answer");
    a_parity_even: assert property (alu_upd_i.acc_we |=>
        view_o.flags[P_BIT] == ^view_o.ab_pair[7:0]) else $error("parity odd");
    a_wrap_clear: assert property (alu_upd_i.ov_clr |=> !view_o.flags[OV_BIT])
        else $error("wrap flag kept");
    a_wrap_copy: assert property (alu_upd_i.bit_test && !alu_upd_i.ov_clr |=>
        view_o.flags[OV_BIT] == $past(alu_upd_i.test_byte[SIGN_COPY_BIT]))
        else $error("bit six not copied");
    a_ip_load: assert property (seq_ctl_i.ip_load |=> view_o.ip == $past(seq_ctl_i.ip_value))
        else $error("ip not loaded");
    a_ip_step: assert property (seq_ctl_i.ip_inc && !seq_ctl_i.ip_load |=>
        view_o.ip == $past(view_o.ip) + ONE16) else $error("ip not stepped");
    a_ptr_step: assert property (seq_ctl_i.ext_inc && !dir_req_i.wr |=>
        view_o.ext_ptr == $past(view_o.ext_ptr) + ONE16) else $error("pointer not stepped");
    a_bank_base: assert property (s_flag_write |=> view_o.bank_base == {3'h0,
        $past(dir_req_i.wdata[RS1_BIT]), $past(dir_req_i.wdata[RS0_BIT]), 3'h0})
        else $error("bank wrong");
    a_move_miss: assert property (xmv_req_i.rd && !xmv_req_i.wr &&
        view_o.ext_control[AUX_RAM_SELECT_BIT_BIT] |=> xmv_rsp_o.valid && xmv_rsp_o.data == XMV_IDLE_DATA)
        else $error("miss data wrong");
endmodule
bind cpu_registers_data_memory_map cpu_map_chk u_chk (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .dir_req_i(dir_req_i), .ind_req_i(ind_req_i),
    .xmv_req_i(xmv_req_i), .stack_req_i(stack_req_i), .alu_upd_i(alu_upd_i),
    .seq_ctl_i(seq_ctl_i), .byte_rsp_o(byte_rsp_o), .xmv_rsp_o(xmv_rsp_o), .view_o(view_o));
`default_nettype wire

// ### tb/cpu_registers_data_memory_map_test.sv
// self-checking bench for the register file and data memory map
`timescale 1ns/1ps
`default_nettype none
module cpu_registers_data_memory_map_test;
    import cpu_regs_pkg::*;
    logic mclk_i;
    logic sys_rst_i = 1'b1;
    byte_req_t dir_req, ind_req;
    bit_req_t bit_req;
    xmv_req_t xmv_req;
    stack_req_t stack_req;
    alu_upd_t alu_upd, au;
    seq_ctl_t seq_ctl;
    byte_rsp_t byte_rsp, xmv_rsp;
    logic bit_valid, bit_data;
    cpu_view_t view;
    int err_total = 0;
    int comparisons = 0;
    cpu_exec_model u (.mclk_i(mclk_i), .dir_req_o(dir_req), .ind_req_o(ind_req),
        .bit_req_o(bit_req), .xmv_req_o(xmv_req), .stack_req_o(stack_req),
        .alu_upd_o(alu_upd), .seq_ctl_o(seq_ctl));
    cpu_registers_data_memory_map dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .dir_req_i(dir_req), .ind_req_i(ind_req), .bit_req_i(bit_req), .xmv_req_i(xmv_req),
        .stack_req_i(stack_req), .alu_upd_i(alu_upd), .seq_ctl_i(seq_ctl),
        .byte_rsp_o(byte_rsp), .xmv_rsp_o(xmv_rsp), .bit_valid_o(bit_valid),
        .bit_data_o(bit_data), .view_o(view));
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // hang guard at 4000 cycles, far beyond the 42 or so cycles the tests need
    initial begin
        #20000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        #1 sys_rst_i = 1'b0;
        chk("ip", IP_RST, view.ip);
        u.mem(0, 1, ADDR_MAIN_OPERAND, 8'h03);
        chk("parity", 0, view.flags[P_BIT]);
        u.mem(0, 1, ADDR_MAIN_OPERAND, 8'h01);
        chk("parity", 1, view.flags[P_BIT]);
        u.mem(0, 1, ADDR_AUX_OPERAND, 8'h5a);
        chk("pair", 16'h5a01, view.ab_pair);
        u.mem(0, 0, ADDR_AUX_OPERAND, 8'h00);
        chk("aux", 16'h015a, {7'h0, byte_rsp});
        u.mem(0, 0, 8'h85, 8'h00);
        chk("unmapped", 16'h0100, {7'h0, byte_rsp});
        u.mem(0, 1, ADDR_EXT_LOW, 8'hff);
        u.seq('{1'b0, 16'h0000, 1'b0, 1'b1});
        chk("pointer", 16'h0100, view.ext_ptr);
        u.seq('{1'b1, 16'h1234, 1'b1, 1'b0});
        u.seq('{1'b0, 16'h0000, 1'b1, 1'b0});
        chk("ip", 16'h1235, view.ip);
        $display("register test done");
        u.mem(0, 1, ADDR_STACK_TOP, 8'h30);
        u.stk(1, 8'h77);
        chk("sp", 16'h0031, view.sp);
        u.mem(1, 0, 8'h31, 8'h00);
        chk("ind", 16'h0177, {7'h0, byte_rsp});
        u.stk(0, 8'h00);
        chk("pop", 16'h3077, {view.sp, byte_rsp.data});
        u.mem(0, 1, ADDR_FLAG_WORD, 8'h18);
        chk("bank", 16'h0018, view.bank_base);
        u.bitop(1, 8'h00, 1'b1);
        u.mem(0, 0, BIT_RAM_BASE, 8'h00);
        chk("bitram", 16'h0101, {7'h0, byte_rsp});
        u.bitop(0, 8'h00, 1'b0);
        chk("bitread", 16'h0003, {bit_valid, bit_data});
        $display("memory test done");
        u.xmv(1, 1, 8'h05, 8'ha5);
        u.xmv(0, 1, 8'h05, 8'h00);
        chk("move", 16'h01a5, {7'h0, xmv_rsp});
        u.mem(0, 1, ADDR_INDEX_PTR, 8'h05);
        u.mem(0, 0, ADDR_WINDOW_PORT, 8'h00);
        chk("window", 16'h00a5, byte_rsp.data);
        u.mem(0, 0, ADDR_INDEX_PTR, 8'h00);
        chk("index", 16'h0006, byte_rsp.data);
        u.mem(0, 1, ADDR_EXT_HIGH, 8'h00);
        u.mem(0, 1, ADDR_EXT_LOW, 8'h05);
        u.xmv(0, 0, 8'h00, 8'h00);
        chk("ptrmove", 16'h00a5, xmv_rsp.data);
        u.bitop(1, ADDR_EXT_CONTROL, 1'b1);
        chk("xctl", 16'h0001, view.ext_control);
        u.xmv(0, 1, 8'h05, 8'h00);
        chk("miss", {8'h01, XMV_IDLE_DATA}, {7'h0, xmv_rsp});
        $display("move test done");
        au = '0;
        au.bit_test = 1'b1;
        au.test_byte = 8'h40;
        u.alu(au);
        chk("copy", 1, view.flags[OV_BIT]);
        au = '0;
        au.ov_clr = 1'b1;
        u.alu(au);
        chk("clear", 0, view.flags[OV_BIT]);
        au = '{1'b1, 8'h07, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
        u.alu(au);
        chk("flags", 16'h00c5, view.flags & 8'hc5);
        $display("flag test done");
        summarize();
    end
endmodule
`default_nettype wire
